// >>> inc/msdma_pkg.sv
// shared constants and types of the multi-stream dma controller
package msdma_pkg;
  localparam int STREAMS = 8;
  localparam int FIFO_BYTES = 8;
  localparam int SDF_COUNT = 4;
  // one stream per sigma-delta filter; periphReq and swTrig bits 4 to 7 also request these streams
  localparam logic [2:0] SDF_STREAM [SDF_COUNT] = '{3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [1:0] DIR_M2M = 2'h0;
  localparam logic [1:0] DIR_P2M = 2'h1;
  localparam logic [1:0] DIR_M2P = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // read beats per grant for burst codes 0..3
  localparam logic [4:0] BURST_BEATS [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [2:0] CUR_RESET = 3'h7;

  typedef struct packed {
    logic enable;
    logic [1:0] dir;
    logic circular;
    logic dbuf;
    logic [1:0] srcSize;
    logic [1:0] dstSize;
    logic perInc;
    logic memInc;
    logic [1:0] burst;
    logic [15:0] count;
    logic [31:0] perAddr;
    logic [31:0] mem0Addr;
    logic [31:0] mem1Addr;
  } msdma_cfg_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] data;
  } msdma_bus_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] data;
  } msdma_bus_rsp_t;

  typedef enum logic [2:0] {
    ST_PICK = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } msdma_state_t;
endpackage

// >>> logic/msdma_controller.sv
// eight-stream dma controller with packing fifos and two bus master ports
`timescale 1ns/1ps
// Behaviour
// RL1: the controller runs eight independent streams and has a read port and a write port.
// RL2: each stream moves memory to memory, peripheral to memory or memory to peripheral.
// RL3: each stream buffers data in its own fifo and holds the bus for a burst of reads.
// RL4: a circular stream reloads count and addresses at buffer end without software.
// RL5: a double-buffer stream switches to the other memory buffer at each buffer end.
// RL6: a stream is paced by its peripheral request lines or started by a software trigger; the code runs memory to memory streams from enable alone.
// RL7: source and destination sizes are set apart and data is packed or unpacked between them.
// RL8: each sigma-delta filter unit requests through a stream of its own.
// RL9: each stream flags completion and bus errors, each flag maskable onto an interrupt.
module msdma_controller (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // stream configuration and requests
  input msdma_pkg::msdma_cfg_t cfg [msdma_pkg::STREAMS],
  input wire logic [7:0] periphReq,
  input wire logic [msdma_pkg::SDF_COUNT-1:0] sdfReq,
  input wire logic [7:0] swTrig,
  // flag control
  input wire logic [7:0] clrDone,
  input wire logic [7:0] clrErr,
  input wire logic [7:0] doneIe,
  input wire logic [7:0] errIe,
  // bus master ports
  output msdma_pkg::msdma_bus_req_t rdBus,
  input msdma_pkg::msdma_bus_rsp_t rdRsp,
  output msdma_pkg::msdma_bus_req_t wrBus,
  input msdma_pkg::msdma_bus_rsp_t wrRsp,
  // status
  output logic [7:0] doneFlag,
  output logic [7:0] errFlag,
  output logic [7:0] irq,
  output logic [7:0] curTarget,
  output logic [7:0] running
);
  localparam int N = msdma_pkg::STREAMS;

  function automatic logic [3:0] unitBytes(input logic [1:0] sz);
    unitBytes = (sz == msdma_pkg::SZ_WORD) ? 4'h4 : (sz == msdma_pkg::SZ_HALF) ? 4'h2 : 4'h1;
  endfunction

  function automatic logic [31:0] step(input logic inc, input logic [1:0] sz);
    step = inc ? {28'h0000000, unitBytes(sz)} : 32'h00000000;
  endfunction

  msdma_pkg::msdma_state_t state, next_state;
  logic [2:0] cur, next_cur;
  logic [4:0] beats, next_beats;
  logic hold, next_hold;
  logic [7:0] enPrev, pend, next_pend, next_run, next_done, next_err, next_tgt, next_irq;
  logic [15:0] count [N];
  logic [15:0] next_count [N];
  logic [31:0] perPtr [N];
  logic [31:0] next_perPtr [N];
  logic [31:0] memPtr [N];
  logic [31:0] next_memPtr [N];
  logic [3:0] level [N];
  logic [3:0] next_level [N];
  logic [7:0] fifo [N][msdma_pkg::FIFO_BYTES];
  logic [7:0] next_fifo [N][msdma_pkg::FIFO_BYTES];
  msdma_pkg::msdma_bus_req_t next_rdBus, next_wrBus;
  logic [7:0] canMove, ready, compl, reqIn;
  logic pickGo;
  logic [2:0] pickIdx;

  always_comb
  begin
    reqIn = periphReq | swTrig; // [RL6]
    for (int f = 0; f < msdma_pkg::SDF_COUNT; f++)
    begin
      if (sdfReq[f])
        reqIn[msdma_pkg::SDF_STREAM[f]] = 1'b1; // [RL8]
    end
    for (int s = 0; s < N; s++)
    begin
      canMove[s] = (level[s] >= unitBytes(cfg[s].dstSize)) ||
                   (count[s] != 16'h0000 &&
                    ({1'b0, level[s]} + {1'b0, unitBytes(cfg[s].srcSize)}) <= 5'h08);
      ready[s] = running[s] && canMove[s] &&
                 (cfg[s].dir == msdma_pkg::DIR_M2M || pend[s]); // [RL6]
      compl[s] = running[s] && count[s] == 16'h0000 &&
                 level[s] < unitBytes(cfg[s].dstSize); // [RL9]
    end
    // round robin from the stream after the last one served
    pickGo = 1'b0;
    pickIdx = cur;
    for (int k = 1; k <= N; k++)
    begin
      if (!pickGo && ready[3'(cur + 3'(k))])
      begin
        pickGo = 1'b1;
        pickIdx = 3'(cur + 3'(k)); // [RL1]
      end
    end
    if (hold && running[cur] && canMove[cur])
    begin
      pickGo = 1'b1;
      pickIdx = cur; // [RL3]
    end
  end

  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_beats = beats;
    next_hold = hold;
    next_pend = pend | reqIn;
    next_run = running;
    next_done = doneFlag & ~clrDone;
    next_err = errFlag & ~clrErr;
    next_tgt = curTarget;
    next_count = count;
    next_perPtr = perPtr;
    next_memPtr = memPtr;
    next_level = level;
    next_fifo = fifo;
    next_rdBus = rdBus;
    next_wrBus = wrBus;
    for (int s = 0; s < N; s++)
    begin
      if (cfg[s].enable && !enPrev[s])
      begin
        next_run[s] = 1'b1;
        next_count[s] = cfg[s].count;
        next_perPtr[s] = cfg[s].perAddr;
        next_memPtr[s] = cfg[s].mem0Addr;
        next_tgt[s] = 1'b0;
        next_level[s] = msdma_pkg::LEVEL_RESET;
      end
      else if (!cfg[s].enable)
        next_run[s] = 1'b0;
      else if (compl[s])
      begin
        next_done[s] = 1'b1; // [RL9]
        next_level[s] = msdma_pkg::LEVEL_RESET;
        if (cfg[s].circular || cfg[s].dbuf)
        begin
          next_count[s] = cfg[s].count; // [RL4]
          next_perPtr[s] = cfg[s].perAddr;
          next_memPtr[s] = cfg[s].mem0Addr;
          if (cfg[s].dbuf)
          begin
            next_tgt[s] = ~curTarget[s]; // [RL5]
            next_memPtr[s] = curTarget[s] ? cfg[s].mem0Addr : cfg[s].mem1Addr;
          end
        end
        else
          next_run[s] = 1'b0;
      end
    end
    case (state)
      msdma_pkg::ST_PICK:
      begin
        // a stale burst must not carry over to a later grant of a stopped stream
        next_hold = 1'b0;
        if (pickGo)
        begin
          next_cur = pickIdx;
          if (!(hold && pickIdx == cur))
          begin
            next_beats = msdma_pkg::BURST_BEATS[cfg[pickIdx].burst]; // [RL3]
            next_pend[pickIdx] = reqIn[pickIdx];
          end
          if (level[pickIdx] >= unitBytes(cfg[pickIdx].dstSize))
          begin
            next_state = msdma_pkg::ST_WRITE;
            next_wrBus.req = 1'b1;
            next_wrBus.size = cfg[pickIdx].dstSize; // [RL7]
            next_wrBus.addr = (cfg[pickIdx].dir == msdma_pkg::DIR_M2P) ?
                              perPtr[pickIdx] : memPtr[pickIdx]; // [RL2]
            next_wrBus.data = {fifo[pickIdx][3], fifo[pickIdx][2],
                               fifo[pickIdx][1], fifo[pickIdx][0]};
          end
          else
          begin
            next_state = msdma_pkg::ST_READ;
            next_rdBus.req = 1'b1;
            next_rdBus.size = cfg[pickIdx].srcSize; // [RL7]
            next_rdBus.addr = (cfg[pickIdx].dir == msdma_pkg::DIR_M2P) ?
                              memPtr[pickIdx] : perPtr[pickIdx]; // [RL2]
          end
        end
      end
      msdma_pkg::ST_READ:
      begin
        if (rdRsp.ack)
        begin
          next_rdBus.req = 1'b0;
          next_state = msdma_pkg::ST_PICK;
          if (rdRsp.err)
          begin
            next_err[cur] = 1'b1; // [RL9]
            next_run[cur] = 1'b0;
            next_level[cur] = msdma_pkg::LEVEL_RESET;
          end
          else
          begin
            // pack source units into the stream fifo, little end first
            for (int b = 0; b < 4; b++)
            begin
              if (4'(b) < unitBytes(cfg[cur].srcSize))
                next_fifo[cur][3'(level[cur] + 4'(b))] = rdRsp.data[8*b +: 8]; // [RL7]
            end
            next_level[cur] = level[cur] + unitBytes(cfg[cur].srcSize); // [RL3]
            next_count[cur] = count[cur] - 16'h0001;
            next_beats = beats - 5'h01;
            next_hold = beats != 5'h01;
            if (cfg[cur].dir == msdma_pkg::DIR_M2P)
              next_memPtr[cur] = memPtr[cur] + step(cfg[cur].memInc, cfg[cur].srcSize);
            else
              next_perPtr[cur] = perPtr[cur] + step(cfg[cur].perInc, cfg[cur].srcSize);
          end
        end
      end
      msdma_pkg::ST_WRITE:
      begin
        if (wrRsp.ack)
        begin
          next_wrBus.req = 1'b0;
          next_state = msdma_pkg::ST_PICK;
          next_hold = beats != 5'h00;
          if (wrRsp.err)
          begin
            next_err[cur] = 1'b1; // [RL9]
            next_run[cur] = 1'b0;
            next_level[cur] = msdma_pkg::LEVEL_RESET;
          end
          else
          begin
            // unpack: shift out the destination unit just written
            for (int b = 0; b < msdma_pkg::FIFO_BYTES; b++)
              next_fifo[cur][b] = fifo[cur][3'(b + int'(unitBytes(cfg[cur].dstSize)))];
            next_level[cur] = level[cur] - unitBytes(cfg[cur].dstSize); // [RL7]
            if (cfg[cur].dir == msdma_pkg::DIR_M2P)
              next_perPtr[cur] = perPtr[cur] + step(cfg[cur].perInc, cfg[cur].dstSize);
            else
              next_memPtr[cur] = memPtr[cur] + step(cfg[cur].memInc, cfg[cur].dstSize);
          end
        end
      end
      default:
        next_state = msdma_pkg::ST_PICK;
    endcase
    // set wins over clear, since it is applied after the clear above
    next_irq = (next_done & doneIe) | (next_err & errIe); // [RL9]
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= msdma_pkg::ST_PICK;
      cur <= msdma_pkg::CUR_RESET;
      beats <= 5'h00;
      hold <= 1'b0;
      enPrev <= 8'h00;
      pend <= 8'h00;
      running <= 8'h00;
      doneFlag <= 8'h00;
      errFlag <= 8'h00;
      curTarget <= 8'h00;
      irq <= 8'h00;
      rdBus <= '0;
      wrBus <= '0;
      for (int s = 0; s < N; s++)
      begin
        count[s] <= 16'h0000;
        perPtr[s] <= 32'h00000000;
        memPtr[s] <= 32'h00000000;
        level[s] <= msdma_pkg::LEVEL_RESET;
        for (int b = 0; b < msdma_pkg::FIFO_BYTES; b++)
          fifo[s][b] <= 8'h00;
      end
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      beats <= next_beats;
      hold <= next_hold;
      for (int s = 0; s < N; s++)
        enPrev[s] <= cfg[s].enable;
      pend <= next_pend;
      running <= next_run;
      doneFlag <= next_done;
      errFlag <= next_err;
      curTarget <= next_tgt;
      irq <= next_irq;
      rdBus <= next_rdBus;
      wrBus <= next_wrBus;
      count <= next_count;
      perPtr <= next_perPtr;
      memPtr <= next_memPtr;
      level <= next_level;
      fifo <= next_fifo;
    end
  end

  a_m2p_source: assert property (@(posedge mclk) disable iff (srst) // [RL2]
    $rose(rdBus.req) && cfg[cur].dir == msdma_pkg::DIR_M2P |-> rdBus.addr == memPtr[cur])
    else $error("memory to peripheral read not from memory pointer");
  a_rd_stable: assert property (@(posedge mclk) disable iff (srst) // [RL3]
    rdBus.req && !rdRsp.ack |=> rdBus.req && $stable(rdBus.addr))
    else $error("read request dropped or moved before acknowledge");
  a_paced_start: assert property (@(posedge mclk) disable iff (srst) // [RL6]
    state == msdma_pkg::ST_PICK && pickGo && !hold &&
    cfg[pickIdx].dir != msdma_pkg::DIR_M2M |-> pend[pickIdx])
    else $error("peripheral stream started without a request");
  a_size_sep: assert property (@(posedge mclk) disable iff (srst) // [RL7]
    $rose(wrBus.req) |-> wrBus.size == cfg[cur].dstSize ##1 wrBus.size == $past(wrBus.size))
    else $error("write size differs from destination size");
  a_err_flag: assert property (@(posedge mclk) disable iff (srst) // [RL9]
    rdBus.req && rdRsp.ack && rdRsp.err |=> errFlag[cur] && !running[cur])
    else $error("read error did not flag and stop the stream");

  for (genvar s = 0; s < N; s++)
  begin : g_chk
    a_circ_reload: assert property (@(posedge mclk) disable iff (srst) // [RL4]
      compl[s] && cfg[s].enable && cfg[s].circular |=> running[s] && count[s] == cfg[s].count)
      else $error("circular stream did not restart");
    a_dbuf_swap: assert property (@(posedge mclk) disable iff (srst) // [RL5]
      compl[s] && cfg[s].enable && cfg[s].dbuf |=> curTarget[s] != $past(curTarget[s]))
      else $error("double buffer target did not switch");
    a_done_flag: assert property (@(posedge mclk) disable iff (srst) // [RL9]
      compl[s] && cfg[s].enable |=> doneFlag[s] ##1 doneFlag[s] || $past(clrDone[s]))
      else $error("completion flag not raised");
  end
  for (genvar f = 0; f < msdma_pkg::SDF_COUNT; f++)
  begin : g_sdf
    a_sdf_own: assert property (@(posedge mclk) disable iff (srst) // [RL8]
      sdfReq[f] |=> pend[msdma_pkg::SDF_STREAM[f]])
      else $error("filter request did not reach its own stream");
  end
endmodule

// >>> test/msdma_mem_model.sv
// byte memory slave answering both master ports of the dma controller
`timescale 1ns/1ps
module msdma_mem_model (
  // clock
  input wire logic mclk,
  // master ports
  input msdma_pkg::msdma_bus_req_t rdBus,
  output msdma_pkg::msdma_bus_rsp_t rdRsp,
  input msdma_pkg::msdma_bus_req_t wrBus,
  output msdma_pkg::msdma_bus_rsp_t wrRsp,
  // stall length and faulting access address
  input wire logic [1:0] latency,
  input wire logic [31:0] errAddr
);
  logic [7:0] mem [int unsigned];
  logic [1:0] rdWait = 2'h0;
  logic [1:0] wrWait = 2'h0;
  logic [31:0] noise = 32'h5a5a_0f0f;
  // read data only means something with ack, so it churns otherwise
  always @(posedge mclk)
  begin
    noise <= {noise[30:0], ~noise[31]};
    rdRsp <= {2'b00, noise};
    if (rdBus.req && !rdRsp.ack)
    begin
      rdWait <= rdWait + 2'h1;
      if (rdWait >= latency)
      begin
        rdWait <= 2'h0;
        rdRsp.ack <= 1'b1;
        rdRsp.err <= rdBus.addr == errAddr;
        for (int i = 0; i < 4; i++)
          rdRsp.data[8*i +: 8] <= mem.exists(rdBus.addr + i) ? mem[rdBus.addr + i] : 8'h00;
      end
    end
  end
  always @(posedge mclk)
  begin
    wrRsp <= '0;
    if (wrBus.req && !wrRsp.ack)
    begin
      wrWait <= wrWait + 2'h1;
      if (wrWait >= latency)
      begin
        wrWait <= 2'h0;
        wrRsp.ack <= 1'b1;
        wrRsp.err <= wrBus.addr == errAddr;
        for (int i = 0; i < (1 << wrBus.size); i++)
          mem[wrBus.addr + i] = wrBus.data[8*i +: 8];
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench of the dma controller against a byte-queue model
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  msdma_pkg::msdma_cfg_t cfg [msdma_pkg::STREAMS] = '{default: '0};
  logic [7:0] periphReq = '0;
  logic [7:0] swTrig = '0;
  logic [7:0] clrDone = '0;
  logic [7:0] clrErr = '0;
  logic [7:0] doneIe = '0;
  logic [7:0] errIe = 8'hff;
  logic [3:0] sdfReq = '0;
  logic [1:0] latency = 2'h0;
  logic [31:0] errAddr = 32'hffff_fff0;
  msdma_pkg::msdma_bus_req_t rdBus, wrBus;
  msdma_pkg::msdma_bus_rsp_t rdRsp, wrRsp;
  logic [7:0] doneFlag, errFlag, irq, curTarget, running;
  logic [31:0] seed = 32'h28c5;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] srcQ [$];
  always #10 mclk = ~mclk;
  msdma_controller DUT (.mclk(mclk), .srst(srst), .cfg(cfg), .periphReq(periphReq),
    .sdfReq(sdfReq), .swTrig(swTrig), .clrDone(clrDone), .clrErr(clrErr), .doneIe(doneIe),
    .errIe(errIe), .rdBus(rdBus), .rdRsp(rdRsp), .wrBus(wrBus), .wrRsp(wrRsp),
    .doneFlag(doneFlag), .errFlag(errFlag), .irq(irq), .curTarget(curTarget),
    .running(running));
  msdma_mem_model PART (.mclk(mclk), .rdBus(rdBus), .rdRsp(rdRsp), .wrBus(wrBus),
    .wrRsp(wrRsp), .latency(latency), .errAddr(errAddr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // request line toggles while waiting, so pacing never stops
  task automatic wait_flag(input int s, input bit pace, input bit sdf, input bit err);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      @(negedge mclk);
      if ((err ? errFlag[s] : doneFlag[s]) === 1'b1)
        break;
      if (pace && sdf)
        sdfReq[s - 4] = ~sdfReq[s - 4];
      else if (pace)
        periphReq[s] = ~periphReq[s];
    end
    if (n == 3000)
    begin
      failures++;
      report_and_stop();
    end
    else
    begin
      periphReq = '0;
      sdfReq = '0;
    end
  endtask
  // mode 0 plain, 1 circular double buffer, 2 read fault, 3 filter paced, 4 masked write fault
  task automatic run(input int s, input logic [1:0] dir, input logic [1:0] ssz,
    input logic [1:0] dsz, input logic [1:0] burst, input int cnt, input int mode);
    int nb;
    int wb;
    logic [31:0] src;
    logic [31:0] dst;
    src = 32'h1000 + 32'h100 * s;
    dst = 32'h8000 + 32'h400 * s;
    nb = cnt << ssz;
    wb = nb >> dsz << dsz;
    srcQ = {};
    for (int i = 0; i < nb; i++)
    begin
      seed = lfsr(seed);
      PART.mem[src + i] = seed[7:0];
      srcQ.push_back(seed[7:0]);
    end
    latency = seed[9:8];
    errAddr = mode == 2 ? src + 2 : mode == 4 ? dst + 32'h1 : 32'hffff_fff0;
    doneIe[s] = s[0];
    errIe[s] = mode != 4;
    cfg[s] = '{1'b0, dir, mode == 1, mode == 1, ssz, dsz, 1'b1, 1'b1, burst, cnt[15:0],
      dir == 2'h2 ? dst : src, dir == 2'h2 ? src : dst, dst + 32'h200};
    @(negedge mclk);
    cfg[s].enable = 1'b1;
    swTrig[s] = 1'b1;
    @(negedge mclk);
    swTrig[s] = 1'b0;
    wait_flag(s, dir != 2'h0, mode == 3, mode == 2 || mode == 4);
    @(negedge mclk);
    if (mode == 2 || mode == 4)
    begin
      `CHK(running[s], 1'b0)
      `CHK(irq[s], mode == 2)
    end
    else
    begin
      for (int i = 0; i < wb; i++)
        `CHK(PART.mem[dst + i], srcQ[i])
      `CHK(irq[s], s[0])
      if (mode == 1)
      begin
        `CHK(curTarget[s], 1'b1)
        clrDone[s] = 1'b1;
        @(negedge mclk);
        clrDone[s] = 1'b0;
        wait_flag(s, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < wb; i++)
          `CHK(PART.mem[dst + 32'h200 + i], srcQ[i])
        `CHK(curTarget[s], 1'b0)
      end
    end
    cfg[s].enable = 1'b0;
    clrDone[s] = 1'b1;
    clrErr[s] = 1'b1;
    @(negedge mclk);
    clrDone = '0;
    clrErr = '0;
    @(negedge mclk);
    `CHK(doneFlag[s] | errFlag[s] | irq[s], 1'b0)
    $display("test of stream %0d finished", s);
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    `CHK({running, doneFlag, errFlag, irq, curTarget, rdBus.req, wrBus.req}, 42'h0)
    run(0, 2'h0, 2'h0, 2'h2, 2'h1, 8, 0);
    run(1, 2'h1, 2'h0, 2'h1, 2'h0, 5, 0);
    run(2, 2'h2, 2'h2, 2'h0, 2'h2, 3, 0);
    run(3, 2'h0, 2'h1, 2'h1, 2'h3, 20, 0);
    run(4, 2'h1, 2'h1, 2'h2, 2'h0, 4, 3);
    run(5, 2'h1, 2'h0, 2'h0, 2'h1, 4, 1);
    run(6, 2'h1, 2'h0, 2'h0, 2'h0, 4, 2);
    run(6, 2'h1, 2'h0, 2'h0, 2'h0, 4, 4);
    run(7, 2'h0, 2'h2, 2'h0, 2'h1, 2, 0);
    report_and_stop();
  end
endmodule
